// ### hw/lcc_defs.svh
// Named constants of the lane configuration registers.
// Assumes inclusion by bare name.
`ifndef LCC_DEFS_SVH
`define LCC_DEFS_SVH

// Register byte addresses
`define LCC_OFS_L1_DEEMPH    8'h18
`define LCC_OFS_L1_IDLE_THR  8'h19
`define LCC_OFS_L2_IDLE_RATE 8'h1c
`define LCC_OFS_L2_EQ        8'h1d
`define LCC_OFS_L2_SWING     8'h1e
`define LCC_OFS_L2_DEEMPH    8'h1f
`define LCC_OFS_L2_IDLE_THR  8'h20
`define LCC_OFS_L3_IDLE_RATE 8'h23

// Storage slot of each register
`define LCC_NUM_REGS         8
`define LCC_IX_L1_DEEMPH     3'h0
`define LCC_IX_L1_IDLE_THR   3'h1
`define LCC_IX_L2_IDLE_RATE  3'h2
`define LCC_IX_L2_EQ         3'h3
`define LCC_IX_L2_SWING      3'h4
`define LCC_IX_L2_DEEMPH     3'h5
`define LCC_IX_L2_IDLE_THR   3'h6
`define LCC_IX_L3_IDLE_RATE  3'h7

// Reset values
`define LCC_RST_DEEMPH       8'h01
`define LCC_RST_IDLE_THR     8'h00
`define LCC_RST_IDLE_RATE    8'h00
`define LCC_RST_EQ           8'h20
`define LCC_RST_SWING        8'h03

// Implemented bits; reserved bits read as zero
`define LCC_MSK_DEEMPH       8'hff
`define LCC_MSK_IDLE_THR     8'h0f
`define LCC_MSK_IDLE_RATE    8'h33
`define LCC_MSK_EQ           8'h3f
`define LCC_MSK_SWING        8'h3f

// Field positions
`define LCC_DE_STYLE_BIT     7
`define LCC_DE_LEVEL_RNG     6:0
`define LCC_THR_DEASSERT_RNG 3:2
`define LCC_THR_ASSERT_RNG   1:0
`define LCC_IR_IDLE_AUTO_BIT 5
`define LCC_IR_IDLE_SEL_BIT  4
`define LCC_IR_RATE_AUTO_BIT 1
`define LCC_IR_RATE_SEL_BIT  0
`define LCC_EQ_EN_BIT        5
`define LCC_EQ_GAIN_RNG      4:3
`define LCC_EQ_BOOST_RNG     2:0
`define LCC_SWING_RNG        5:0
`define LCC_EQ_RNG           5:0

// De-emphasis codes and their depth in tenths of a dB
`define LCC_DE_0DB           8'h01
`define LCC_DE_3P5DB         8'he8
`define LCC_DE_6DB           8'h88
`define LCC_DE_9DB           8'h90
`define LCC_DE_12DB          8'ha0
`define LCC_DE_RESERVED      8'hc0
`define LCC_DB_0             8'h00
`define LCC_DB_3P5           8'h23
`define LCC_DB_6             8'h3c
`define LCC_DB_9             8'h5a
`define LCC_DB_12            8'h78

// Idle threshold codes and levels in mV
`define LCC_THR_C0           2'h0
`define LCC_THR_C1           2'h1
`define LCC_THR_C2           2'h2
`define LCC_THR_C3           2'h3
`define LCC_DEASSERT_MV_C0   8'h6e
`define LCC_DEASSERT_MV_C1   8'h96
`define LCC_DEASSERT_MV_C2   8'haa
`define LCC_DEASSERT_MV_C3   8'hbe
`define LCC_ASSERT_MV_C0     8'h46
`define LCC_ASSERT_MV_C1     8'h6e
`define LCC_ASSERT_MV_C2     8'h82
`define LCC_ASSERT_MV_C3     8'h96

// Output swing codes and levels in mV
`define LCC_SW_600           6'h03
`define LCC_SW_800           6'h07
`define LCC_SW_1000          6'h0f
`define LCC_SW_1200          6'h1f
`define LCC_MV_600           11'h258
`define LCC_MV_800           11'h320
`define LCC_MV_1000          11'h3e8
`define LCC_MV_1200          11'h4b0

// Strap-equivalent equalizer settings, weakest first
`define LCC_EQ_BYPASS        6'h20
`define LCC_EQ_S1            6'h2a
`define LCC_EQ_S2            6'h30
`define LCC_EQ_S3            6'h32
`define LCC_EQ_S4            6'h35
`define LCC_EQ_S5            6'h37
`define LCC_EQ_S6            6'h3b
`define LCC_EQ_S7            6'h3d

`endif

// ### hw/lcc_pkg.sv
// Types shared by the lane configuration modules.
// Assumes lcc_defs.svh is on the include path.
`include "lcc_defs.svh"

package lcc_pkg;

	// Register storage, one byte per slot
	typedef logic [`LCC_NUM_REGS-1:0][7:0] lcc_regs_t;

	// Decoded de-emphasis setting
	typedef struct packed {
		logic       style;
		logic [6:0] level;
		logic [7:0] db_x10;
		logic       known;
		logic       reserved;
	} lcc_deemph_t;

	// Decoded idle thresholds
	typedef struct packed {
		logic [7:0] deassert_mv;
		logic [7:0] assert_mv;
	} lcc_idle_thr_t;

	// Decoded idle and rate selection
	typedef struct packed {
		logic mute;
		logic sd_en;
		logic rate_5g;
		logic rate_auto;
	} lcc_idle_rate_t;

	// Decoded equalizer setting
	typedef struct packed {
		logic       enable;
		logic [1:0] gain;
		logic [2:0] boost;
		logic       known;
	} lcc_eq_t;

	// Decoded output swing
	typedef struct packed {
		logic [10:0] mv;
		logic        known;
	} lcc_swing_t;

	// Register bank state
	typedef struct packed {
		lcc_regs_t  regs;
		logic [7:0] rdata;
		logic       rvalid;
		logic       err;
	} lcc_bank_state_t;

	// Reset synchroniser state
	typedef struct packed {
		logic [1:0] sr;
	} lcc_sync_state_t;

	// Decoded lane settings driven out of the top
	typedef struct packed {
		lcc_deemph_t    l1_de;
		lcc_idle_thr_t  l1_thr;
		lcc_idle_rate_t l2_ir;
		lcc_eq_t        l2_eq;
		lcc_swing_t     l2_sw;
		lcc_deemph_t    l2_de;
		lcc_idle_thr_t  l2_thr;
		lcc_idle_rate_t l3_ir;
	} lcc_cfg_state_t;

endpackage

// ### hw/lcc_reset_sync.sv
// Reset synchroniser: asserts at once, releases after two edges.
// Assumes resetn may be asynchronous to clk.
`timescale 1ns/1ps

module lcc_reset_sync
	import lcc_pkg::*;
(
	// Clock
	input  wire logic clk,
	input  wire logic ce,
	// Resets
	input  wire logic resetn,
	output logic      rst_n
);

	lcc_sync_state_t s;
	lcc_sync_state_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// Shift a one in; only the second stage is read outside
	always_comb begin
		next_s    = s;
		next_s.sr = {s.sr[0], 1'b1};
	end

	// Frozen with the rest while ce is low, so release waits for ce too
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign rst_n = s.sr[1];

endmodule // lcc_reset_sync

// ### hw/lcc_reg_bank.sv
// Register storage with decode, write masking and registered read.
// Assumes one access per cycle.
`timescale 1ns/1ps
`include "lcc_defs.svh"

module lcc_reg_bank
	import lcc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       ce,
	input  wire logic       rst_n,
	// Access port
	input  wire logic [7:0] addr,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	output logic            rvalid,
	output logic            err,
	// Stored values
	output lcc_regs_t       regs
);

	lcc_bank_state_t s;
	lcc_bank_state_t next_s;
	logic            hit;
	logic [2:0]      ix;

	////////////////////////////////////////////////////////////////////////////
	// Address to slot; hit low for anything unmapped
	function automatic logic [3:0] lcc_decode(input logic [7:0] a);
		unique case (a)
			`LCC_OFS_L1_DEEMPH:    lcc_decode = {1'b1, `LCC_IX_L1_DEEMPH};
			`LCC_OFS_L1_IDLE_THR:  lcc_decode = {1'b1, `LCC_IX_L1_IDLE_THR};
			`LCC_OFS_L2_IDLE_RATE: lcc_decode = {1'b1, `LCC_IX_L2_IDLE_RATE};
			`LCC_OFS_L2_EQ:        lcc_decode = {1'b1, `LCC_IX_L2_EQ};
			`LCC_OFS_L2_SWING:     lcc_decode = {1'b1, `LCC_IX_L2_SWING};
			`LCC_OFS_L2_DEEMPH:    lcc_decode = {1'b1, `LCC_IX_L2_DEEMPH};
			`LCC_OFS_L2_IDLE_THR:  lcc_decode = {1'b1, `LCC_IX_L2_IDLE_THR};
			`LCC_OFS_L3_IDLE_RATE: lcc_decode = {1'b1, `LCC_IX_L3_IDLE_RATE};
			default:               lcc_decode = 4'h0;
		endcase
	endfunction

	// Implemented bits of each slot
	function automatic logic [7:0] lcc_mask(input logic [2:0] i);
		unique case (i)
			`LCC_IX_L1_DEEMPH, `LCC_IX_L2_DEEMPH:        lcc_mask = `LCC_MSK_DEEMPH;
			`LCC_IX_L1_IDLE_THR, `LCC_IX_L2_IDLE_THR:    lcc_mask = `LCC_MSK_IDLE_THR;
			`LCC_IX_L2_IDLE_RATE, `LCC_IX_L3_IDLE_RATE:  lcc_mask = `LCC_MSK_IDLE_RATE;
			`LCC_IX_L2_EQ:                               lcc_mask = `LCC_MSK_EQ;
			`LCC_IX_L2_SWING:                            lcc_mask = `LCC_MSK_SWING;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Decode shared by reads and writes
	always_comb begin
		{hit, ix} = lcc_decode(addr);
	end

	// Writes hold until rewritten or reset; reads see the old value
	always_comb begin
		next_s        = s;
		next_s.rvalid = rd;
		next_s.err    = (rd || wr) && !hit;
		if (rd) begin
			next_s.rdata = hit ? s.regs[ix] : 8'h00;
		end
		if (wr && hit) begin
			next_s.regs[ix] = wdata & lcc_mask(ix);
		end
	end

	// Reset values of each slot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s                            <= '0;
			s.regs                       <= {`LCC_RST_IDLE_RATE, `LCC_RST_IDLE_THR,
				`LCC_RST_DEEMPH, `LCC_RST_SWING, `LCC_RST_EQ, `LCC_RST_IDLE_RATE,
				`LCC_RST_IDLE_THR, `LCC_RST_DEEMPH};
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign rdata  = s.rdata;
	assign rvalid = s.rvalid;
	assign err    = s.err;
	assign regs   = s.regs;

endmodule // lcc_reg_bank

// ### hw/lcc_lane_config.sv
// Lane configuration registers and their decoded settings.
// Assumes all inputs but resetn are synchronous to clk.

`timescale 1ns/1ps
`include "lcc_defs.svh"

module lcc_lane_config
	import lcc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        resetn,

	// Register access port
	input  wire logic  [7:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic  [7:0] reg_wdata,
	output logic       [7:0] reg_rdata,
	output logic             reg_rvalid,
	output logic             reg_err,

	// Lane detectors
	input  wire logic        lane2_idle_detect,
	input  wire logic        lane2_rate_detect_5g,
	input  wire logic        lane3_idle_detect,
	input  wire logic        lane3_rate_detect_5g,

	// Lane 1 output de-emphasis
	output logic             lane1_deemphasis_style,
	output logic       [6:0] lane1_deemphasis_level,
	output logic       [7:0] lane1_deemphasis_db_x10,
	output logic             lane1_deemphasis_known,
	output logic             lane1_deemphasis_reserved,

	// Lane 1 idle thresholds
	output logic       [7:0] lane1_idle_deassert_mv,
	output logic       [7:0] lane1_idle_assert_mv,

	// Lane 2 idle and rate
	output logic             lane2_output_mute,
	output logic             lane2_signal_detect_en,
	output logic             lane2_rate_5g,
	output logic             lane2_rate_auto,

	// Lane 2 input equalizer
	output logic             lane2_eq_enable,
	output logic       [1:0] lane2_gain_stage,
	output logic       [2:0] lane2_boost_level,
	output logic             lane2_eq_known,

	// Lane 2 output swing
	output logic      [10:0] lane2_output_swing_mv,
	output logic             lane2_output_swing_known,

	// Lane 2 output de-emphasis
	output logic             lane2_deemphasis_style,
	output logic       [6:0] lane2_deemphasis_level,
	output logic       [7:0] lane2_deemphasis_db_x10,
	output logic             lane2_deemphasis_known,
	output logic             lane2_deemphasis_reserved,

	// Lane 2 idle thresholds
	output logic       [7:0] lane2_idle_deassert_mv,
	output logic       [7:0] lane2_idle_assert_mv,

	// Lane 3 idle and rate
	output logic             lane3_output_mute,
	output logic             lane3_signal_detect_en,
	output logic             lane3_rate_5g,
	output logic             lane3_rate_auto
);

	lcc_cfg_state_t s;
	lcc_cfg_state_t next_s;
	lcc_regs_t      regs;
	logic           rst_n;

	////////////////////////////////////////////////////////////////////////////
	// De-emphasis byte to style, level and depth
	function automatic lcc_deemph_t lcc_dec_deemph(input logic [7:0] r);
		lcc_deemph_t d;

		d          = '0;
		d.style    = r[`LCC_DE_STYLE_BIT];
		d.level    = r[`LCC_DE_LEVEL_RNG];
		d.known    = 1'b1;
		// C0h is flagged, not acted on; software keeps away from it
		d.reserved = (r == `LCC_DE_RESERVED);

		unique case (r)
			`LCC_DE_0DB:   d.db_x10 = `LCC_DB_0;
			`LCC_DE_3P5DB: d.db_x10 = `LCC_DB_3P5;
			`LCC_DE_6DB:   d.db_x10 = `LCC_DB_6;
			`LCC_DE_9DB:   d.db_x10 = `LCC_DB_9;
			`LCC_DE_12DB:  d.db_x10 = `LCC_DB_12;
			default: begin
				d.db_x10 = `LCC_DB_0;
				d.known  = 1'b0;
			end
		endcase
		return d;
	endfunction

	// One threshold code to its de-assert and assert levels
	function automatic logic [15:0] lcc_thr_mv(input logic [1:0] c);
		unique case (c)
			`LCC_THR_C0: lcc_thr_mv = {`LCC_DEASSERT_MV_C0, `LCC_ASSERT_MV_C0};
			`LCC_THR_C1: lcc_thr_mv = {`LCC_DEASSERT_MV_C1, `LCC_ASSERT_MV_C1};
			`LCC_THR_C2: lcc_thr_mv = {`LCC_DEASSERT_MV_C2, `LCC_ASSERT_MV_C2};
			`LCC_THR_C3: lcc_thr_mv = {`LCC_DEASSERT_MV_C3, `LCC_ASSERT_MV_C3};
		endcase
	endfunction

	// Threshold byte: each half of the field picks its own code
	function automatic lcc_idle_thr_t lcc_dec_thr(input logic [7:0] r);
		lcc_idle_thr_t t;
		logic [15:0]   de;
		logic [15:0]   as;

		de            = lcc_thr_mv(r[`LCC_THR_DEASSERT_RNG]);
		as            = lcc_thr_mv(r[`LCC_THR_ASSERT_RNG]);
		t.deassert_mv = de[15:8];
		t.assert_mv   = as[7:0];

		return t;
	endfunction

	// Idle and rate byte, with the lane's own detectors for auto modes
	function automatic lcc_idle_rate_t lcc_dec_ir(input logic [7:0] r,
		input logic idle_det, input logic rate_det);
		lcc_idle_rate_t v;

		v = '0;
		if (r[`LCC_IR_IDLE_AUTO_BIT]) begin
			v.mute  = idle_det;
			v.sd_en = 1'b1;
		end else begin
			v.mute  = r[`LCC_IR_IDLE_SEL_BIT];
			v.sd_en = 1'b0;
		end

		v.rate_auto = r[`LCC_IR_RATE_AUTO_BIT];
		v.rate_5g   = v.rate_auto ? rate_det : r[`LCC_IR_RATE_SEL_BIT];

		return v;
	endfunction

	// Equalizer byte to enable, gain and boost
	function automatic lcc_eq_t lcc_dec_eq(input logic [7:0] r);
		lcc_eq_t e;

		e.enable = r[`LCC_EQ_EN_BIT];
		e.gain   = r[`LCC_EQ_GAIN_RNG];
		e.boost  = r[`LCC_EQ_BOOST_RNG];

		// Other codes still drive the fields; known only marks strap steps
		unique case (r[`LCC_EQ_RNG])
			`LCC_EQ_BYPASS, `LCC_EQ_S1, `LCC_EQ_S2, `LCC_EQ_S3,
			`LCC_EQ_S4, `LCC_EQ_S5, `LCC_EQ_S6, `LCC_EQ_S7: begin
				e.known = 1'b1;
			end
			default: begin
				e.known = 1'b0;
			end
		endcase
		return e;
	endfunction

	// Swing field to millivolts
	function automatic lcc_swing_t lcc_dec_swing(input logic [7:0] r);
		lcc_swing_t w;

		w.known = 1'b1;
		unique case (r[`LCC_SWING_RNG])
			`LCC_SW_600:  w.mv = `LCC_MV_600;
			`LCC_SW_800:  w.mv = `LCC_MV_800;
			`LCC_SW_1000: w.mv = `LCC_MV_1000;
			`LCC_SW_1200: w.mv = `LCC_MV_1200;
			default: begin
				w.mv    = `LCC_MV_600;
				w.known = 1'b0;
			end
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Reset release
	lcc_reset_sync u_reset_sync (
		.clk    (clk),
		.ce     (ce),
		.resetn (resetn),
		.rst_n  (rst_n)
	);

	// Register storage and access port
	lcc_reg_bank u_reg_bank (
		.clk    (clk),
		.ce     (ce),
		.rst_n  (rst_n),
		.addr   (reg_addr),
		.wr     (reg_wr),
		.rd     (reg_rd),
		.wdata  (reg_wdata),
		.rdata  (reg_rdata),
		.rvalid (reg_rvalid),
		.err    (reg_err),
		.regs   (regs)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decode every register each cycle; outputs trail the store by one edge
	always_comb begin
		next_s        = s;
		next_s.l1_de  = lcc_dec_deemph(regs[`LCC_IX_L1_DEEMPH]);
		next_s.l1_thr = lcc_dec_thr(regs[`LCC_IX_L1_IDLE_THR]);

		next_s.l2_ir  = lcc_dec_ir(regs[`LCC_IX_L2_IDLE_RATE],
			lane2_idle_detect, lane2_rate_detect_5g);
		next_s.l2_eq  = lcc_dec_eq(regs[`LCC_IX_L2_EQ]);
		next_s.l2_sw  = lcc_dec_swing(regs[`LCC_IX_L2_SWING]);
		next_s.l2_de  = lcc_dec_deemph(regs[`LCC_IX_L2_DEEMPH]);
		next_s.l2_thr = lcc_dec_thr(regs[`LCC_IX_L2_IDLE_THR]);

		next_s.l3_ir  = lcc_dec_ir(regs[`LCC_IX_L3_IDLE_RATE],
			lane3_idle_detect, lane3_rate_detect_5g);
	end

	// Reset shows the decode of the register reset values
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s                 <= '0;
			s.l1_de           <= {`LCC_RST_DEEMPH, `LCC_DB_0, 1'b1, 1'b0};
			s.l1_thr          <= {`LCC_DEASSERT_MV_C0, `LCC_ASSERT_MV_C0};
			s.l2_eq           <= {`LCC_EQ_BYPASS, 1'b1};
			s.l2_sw           <= {`LCC_MV_600, 1'b1};
			s.l2_de           <= {`LCC_RST_DEEMPH, `LCC_DB_0, 1'b1, 1'b0};
			s.l2_thr          <= {`LCC_DEASSERT_MV_C0, `LCC_ASSERT_MV_C0};
		end else if (ce) begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign lane1_deemphasis_style    = s.l1_de.style;
	assign lane1_deemphasis_level    = s.l1_de.level;
	assign lane1_deemphasis_db_x10   = s.l1_de.db_x10;
	assign lane1_deemphasis_known    = s.l1_de.known;
	assign lane1_deemphasis_reserved = s.l1_de.reserved;

	assign lane1_idle_deassert_mv    = s.l1_thr.deassert_mv;
	assign lane1_idle_assert_mv      = s.l1_thr.assert_mv;

	assign lane2_output_mute         = s.l2_ir.mute;
	assign lane2_signal_detect_en    = s.l2_ir.sd_en;
	assign lane2_rate_5g             = s.l2_ir.rate_5g;
	assign lane2_rate_auto           = s.l2_ir.rate_auto;

	assign lane2_eq_enable           = s.l2_eq.enable;
	assign lane2_gain_stage          = s.l2_eq.gain;
	assign lane2_boost_level         = s.l2_eq.boost;
	assign lane2_eq_known            = s.l2_eq.known;

	assign lane2_output_swing_mv     = s.l2_sw.mv;
	assign lane2_output_swing_known  = s.l2_sw.known;

	assign lane2_deemphasis_style    = s.l2_de.style;
	assign lane2_deemphasis_level    = s.l2_de.level;
	assign lane2_deemphasis_db_x10   = s.l2_de.db_x10;
	assign lane2_deemphasis_known    = s.l2_de.known;
	assign lane2_deemphasis_reserved = s.l2_de.reserved;

	assign lane2_idle_deassert_mv    = s.l2_thr.deassert_mv;
	assign lane2_idle_assert_mv      = s.l2_thr.assert_mv;

	assign lane3_output_mute         = s.l3_ir.mute;
	assign lane3_signal_detect_en    = s.l3_ir.sd_en;
	assign lane3_rate_5g             = s.l3_ir.rate_5g;
	assign lane3_rate_auto           = s.l3_ir.rate_auto;

endmodule // lcc_lane_config

// ### verification/lcc_lane_config_asserts.sv
// Checker of access answers and decoded lane 2 settings.
// Assumes it is bound to lcc_lane_config.
`timescale 1ns/1ps

module lcc_lane_config_asserts
	import lcc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        ce,
	input wire logic        resetn,
	// Access port
	input wire logic  [7:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic  [7:0] reg_wdata,
	input wire logic  [7:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        reg_err,
	// Lane 2 detectors and settings
	input wire logic        lane2_idle_detect,
	input wire logic        lane2_rate_detect_5g,
	input wire logic        lane2_output_mute,
	input wire logic        lane2_signal_detect_en,
	input wire logic        lane2_rate_5g,
	input wire logic        lane2_eq_enable,
	input wire logic  [1:0] lane2_gain_stage,
	input wire logic  [2:0] lane2_boost_level,
	input wire logic [10:0] lane2_output_swing_mv,
	input wire logic  [7:0] lane2_idle_deassert_mv,
	input wire logic  [7:0] lane2_idle_assert_mv
);
	logic [7:0] ir, eq, sw, th, ir_d, eq_d, sw_d, th_d;
	logic       mapped, idet_d, rdet_d;

	// Threshold levels, de-assert in the upper byte
	function automatic logic [15:0] thr(input logic [3:0] c);
		logic [7:0] d [4] = '{8'h6e, 8'h96, 8'haa, 8'hbe};
		logic [7:0] a [4] = '{8'h46, 8'h6e, 8'h82, 8'h96};
		return {d[c[3:2]], a[c[1:0]]};
	endfunction

	// Swing in mV; unknown codes fall back to the reset swing
	function automatic logic [10:0] smv(input logic [5:0] v);
		case (v)
			6'h07: return 11'h320;
			6'h0f: return 11'h3e8;
			6'h1f: return 11'h4b0;
			default: return 11'h258;
		endcase
	endfunction

	assign mapped = reg_addr inside {8'h18, 8'h19, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h23};

	// Shadow store, then a copy one edge later to match the decode stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{ir, eq, sw, th} <= 32'h00200300;
			{ir_d, eq_d, sw_d, th_d, idet_d, rdet_d} <= {32'h00200300, 2'h0};
		end else if (ce) begin
			{ir_d, eq_d, sw_d, th_d} <= {ir, eq, sw, th};
			{idet_d, rdet_d} <= {lane2_idle_detect, lane2_rate_detect_5g};
			if (reg_wr && reg_addr == 8'h1c) ir <= reg_wdata & 8'h33;
			if (reg_wr && reg_addr == 8'h1d) eq <= reg_wdata & 8'h3f;
			if (reg_wr && reg_addr == 8'h1e) sw <= reg_wdata & 8'h3f;
			if (reg_wr && reg_addr == 8'h20) th <= reg_wdata & 8'h0f;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_read_valid: assert property (ce && reg_rd && mapped |=> reg_rvalid && !reg_err)
		else $error("read gave no valid");
	chk_bad_addr: assert property (ce && (reg_rd || reg_wr) && !mapped |=> reg_err)
		else $error("unmapped access not flagged");
	chk_thr_levels: assert property ({lane2_idle_deassert_mv, lane2_idle_assert_mv} == thr(th_d[3:0]))
		else $error("thresholds differ from codes");
	chk_idle_mute: assert property (lane2_output_mute == (ir_d[5] ? idet_d : ir_d[4]))
		else $error("mute wrong for idle mode");
	chk_sd_manual: assert property (!ir_d[5] |-> !lane2_signal_detect_en)
		else $error("detection left on in manual idle");
	chk_rate_sel: assert property (lane2_rate_5g == (ir_d[1] ? rdet_d : ir_d[0]))
		else $error("rate does not follow rate mode");
	chk_eq_fields: assert property ({lane2_eq_enable, lane2_gain_stage, lane2_boost_level} == eq_d[5:0])
		else $error("equalizer fields differ");
	chk_swing_mv: assert property (lane2_output_swing_mv == smv(sw_d[5:0]))
		else $error("swing level differs");
endmodule // lcc_lane_config_asserts

// ### verification/lcc_host_model.sv
// Management host model: single byte writes and reads.
// Assumes one caller at a time and the answer one edge after taking.
`timescale 1ns/1ps

module lcc_host_model (
	// Clock
	input  wire logic       clk,
	// Access port towards the block
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	input  wire logic       reg_err
);
	// Idle port at time zero
	initial begin
		{reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
	end

	// Write; released lines show the inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d; // Callers pass legal codes only
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	// Read; answer taken once settled
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v, output logic e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		{d, v, e} = {reg_rdata, reg_rvalid, reg_err};
	endtask
endmodule // lcc_host_model

// ### verification/lcc_lane_config_bench.sv
// Self-checking bench of the lane registers.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps

module lcc_lane_config_bench;
	logic        clk, ce, resetn, reg_wr, reg_rd, reg_rvalid, reg_err;
	logic        lane2_idle_detect, lane2_rate_detect_5g, lane3_idle_detect, lane3_rate_detect_5g;
	logic  [7:0] reg_addr, reg_wdata, reg_rdata, lane1_deemphasis_db_x10, lane2_deemphasis_db_x10;
	logic  [7:0] lane1_idle_deassert_mv, lane1_idle_assert_mv;
	logic  [7:0] lane2_idle_deassert_mv, lane2_idle_assert_mv;
	logic  [6:0] lane1_deemphasis_level, lane2_deemphasis_level;
	logic        lane1_deemphasis_style, lane1_deemphasis_known, lane1_deemphasis_reserved;
	logic        lane2_deemphasis_style, lane2_deemphasis_known, lane2_deemphasis_reserved;
	logic        lane2_output_mute, lane2_signal_detect_en, lane2_rate_5g, lane2_rate_auto;
	logic        lane3_output_mute, lane3_signal_detect_en, lane3_rate_5g, lane3_rate_auto;
	logic        lane2_eq_enable, lane2_eq_known, lane2_output_swing_known;
	logic  [1:0] lane2_gain_stage;
	logic  [2:0] lane2_boost_level;
	logic [10:0] lane2_output_swing_mv;
	int          error_cnt, checks_done, cyc;

	lcc_lane_config u_lcc_lane_config (.*);
	lcc_host_model u_lcc_host_model (.*);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp11(input logic [10:0] got, input logic [10:0] exp);
		cmp8({5'h0, got[10:8]}, {5'h0, exp[10:8]});
		cmp8(got[7:0], exp[7:0]);
	endtask

	// Write, then let store and decode edges pass
	task automatic wset(input logic [7:0] a, input logic [7:0] d);
		u_lcc_host_model.wr(a, d);
		repeat (2) @(negedge clk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic bad);
		logic [7:0] d;
		logic       v, x;
		u_lcc_host_model.rd(a, d, v, x);
		cmp8(d, e);
		cmp8({6'h0, v, x}, {7'h1, bad});
	endtask

	////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] ofs [8] = '{8'h18, 8'h19, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h23};
		logic [7:0] rv  [8] = '{8'h01, 8'h00, 8'h00, 8'h20, 8'h03, 8'h01, 8'h00, 8'h00};
		@(posedge clk);
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++) rdchk(ofs[i], rv[i], 1'b0);
		cmp11(lane2_output_swing_mv, 11'h258);
	endtask

	task automatic t_deemph();
		logic [7:0] code [5] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0};
		logic [7:0] db   [5] = '{8'h00, 8'h23, 8'h3c, 8'h5a, 8'h78};
		for (int i = 4; i >= 0; i--) begin
			wset(8'h1f, code[i]);
			cmp8(lane2_deemphasis_db_x10, db[i]);
			cmp8({lane2_deemphasis_style, lane2_deemphasis_level}, code[i]);
			cmp8({6'h0, lane2_deemphasis_known, lane2_deemphasis_reserved}, 8'h02);
			wset(8'h18, code[4 - i]);
			cmp8(lane1_deemphasis_db_x10, db[4 - i]);
			cmp8({lane1_deemphasis_style, lane1_deemphasis_level}, code[4 - i]);
			cmp8({6'h0, lane1_deemphasis_known, lane1_deemphasis_reserved}, 8'h02);
		end
	endtask

	task automatic t_thresh();
		logic [7:0] dm [4] = '{8'h6e, 8'h96, 8'haa, 8'hbe};
		logic [7:0] am [4] = '{8'h46, 8'h6e, 8'h82, 8'h96};
		for (int c = 0; c < 4; c++) begin
			wset(8'h19, 8'((c << 2) | (3 - c)));
			cmp8(lane1_idle_deassert_mv, dm[c]);
			cmp8(lane1_idle_assert_mv, am[3 - c]);
			wset(8'h20, 8'(c * 5));
			cmp8(lane2_idle_assert_mv, am[c]);
		end
	endtask

	// Rows: value, detectors, then mute, detect enable, rate, auto rate
	task automatic t_idle_rate();
		logic [7:0] v  [7] = '{8'h10, 8'h00, 8'h20, 8'h30, 8'h01, 8'h02, 8'h03};
		logic [1:0] dt [7] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2};
		logic [3:0] ex [7] = '{4'h8, 4'h0, 4'hc, 4'h4, 4'h2, 4'h3, 4'h1};
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			{lane2_idle_detect, lane2_rate_detect_5g} <= dt[i];
			{lane3_idle_detect, lane3_rate_detect_5g} <= dt[i];
			wset(8'h1c, v[i]);
			wset(8'h23, v[i]);
			cmp8({4'h0, lane2_output_mute, lane2_signal_detect_en, lane2_rate_5g, lane2_rate_auto}, {4'h0, ex[i]});
			cmp8({4'h0, lane3_output_mute, lane3_signal_detect_en, lane3_rate_5g, lane3_rate_auto}, {4'h0, ex[i]});
		end
	endtask

	task automatic t_eq_swing();
		logic [7:0]  eq [8] = '{8'h20, 8'h2a, 8'h30, 8'h32, 8'h35, 8'h37, 8'h3b, 8'h3d};
		logic [7:0]  sw [4] = '{8'h03, 8'h07, 8'h0f, 8'h1f};
		logic [10:0] mv [4] = '{11'h258, 11'h320, 11'h3e8, 11'h4b0};
		for (int i = 0; i < 8; i++) begin
			wset(8'h1d, eq[i]);
			cmp8({1'b0, lane2_eq_known, lane2_eq_enable, lane2_gain_stage, lane2_boost_level}, {2'h1, eq[i][5:0]});
		end
		for (int i = 0; i < 4; i++) begin
			wset(8'h1e, sw[i]);
			cmp11(lane2_output_swing_mv, mv[i]);
			cmp8({7'h0, lane2_output_swing_known}, 8'h01);
		end
	endtask

	// Unmapped access, a write while frozen, then values still held
	task automatic t_access();
		rdchk(8'h21, 8'h00, 1'b1);
		u_lcc_host_model.wr(8'h22, 8'h07);
		@(negedge clk);
		cmp8({7'h0, reg_err}, 8'h01);
		@(posedge clk);
		ce <= 1'b0;
		u_lcc_host_model.wr(8'h1e, 8'h03);
		@(posedge clk);
		ce <= 1'b1;
		rdchk(8'h1e, 8'h1f, 1'b0);
		rdchk(8'h18, 8'ha0, 1'b0);
		rdchk(8'h19, 8'h0c, 1'b0);
	endtask

	////////////////////////////////////////
	task automatic wrap_up();
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard; the run needs under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// Main sequence; the second reset comes last, after t_access
	initial begin
		{ce, resetn, lane2_idle_detect, lane2_rate_detect_5g} = 4'h8;
		{lane3_idle_detect, lane3_rate_detect_5g} = 2'h0;
		t_reset();
		t_deemph();
		t_thresh();
		t_idle_rate();
		t_eq_swing();
		t_access();
		t_reset();
		wrap_up();
	end
endmodule // lcc_lane_config_bench

bind lcc_lane_config lcc_lane_config_asserts u_lcc_lane_config_asserts (.*);
